// ### hdl/cbb_unit.sv
// Functional notes
// - Compare-skip-equal skips on equal registers; no flags; 1-3 cycles.
// - Compares subtract without writeback, update Z N V C H, one cycle.
// - Register bit skips test a bit, skip on clear or set; no flags.
// - I/O bit skips test an I/O bit, skip on clear or set; no flags.
// - Indexed flag branches go to PC plus offset plus one; no flags.
// - Named branches test Z, C or N set or clear; one or two cycles.
// - Signed branches use N xor V: zero for greater-equal, one for less.
// - Further branches test H, T or V, each set and clear variant.
// - Interrupt-state branches test the global interrupt flag; no flags.
// - I/O set and clear force one bit, keep the rest, two cycles.
// - Left shift fills zero, left rotate fills carry; update Z C N V.
// - Right shifts fill bit 7 with zero, carry, or itself (arithmetic).
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "cbb_map.svh"

module cbb_unit
	import cbb_pkg::*;
#(
	parameter int PC_W = 16
)
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        issue_valid,
	input  wire cbb_issue_s  issue,
	output logic             issue_ready,
	output logic             res_valid,
	output cbb_result_s      res,
	output logic [7:0]       status_register,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [7:0]       reg_rdata
);

	if (PC_W < 8 || PC_W > 16) begin : g_pc_w_check
		$error("cbb_unit: PC_W must lie between 8 and 16");
	end

	cbb_state_e       state_q;
	logic [1:0]       cnt_q;
	cbb_result_s      pend_q;
	cbb_result_s      res_q;
	logic             res_valid_q;
	logic [7:0]       status_register_q;
	logic [7:0]       ctrl_q;
	logic             last_taken_q;
	logic [7:0]       taken_cnt_q;
	logic [7:0]       rdata_q;

	logic             take;
	logic             hit;
	logic             is_skip;
	logic             is_branch;
	logic             is_io_bit;
	logic [1:0]       cyc;
	logic [PC_W-1:0]  pc_cur;
	logic [PC_W-1:0]  pc_inc;
	logic [PC_W-1:0]  pc_new;
	logic [PC_W-1:0]  k_ext;
	logic [7:0]       alu_b;
	logic [7:0]       alu_res;
	logic [7:0]       alu_flags;
	logic             alu_flags_wr;
	logic [7:0]       io_forced;
	cbb_result_s      calc;
	logic [7:0]       fl;

	assign fl = status_register_q;
	assign issue_ready = (state_q == ST_IDLE) & ctrl_q[`CBB_CTRL_EN];
	assign take = ce & issue_valid & issue_ready;
	assign res_valid = res_valid_q;
	assign res = res_q;
	assign status_register = status_register_q;
	assign reg_rdata = rdata_q;

	assign alu_b = (issue.op == OP_COMPARE_IMMEDIATE) ? issue.imm
		: issue.rr_val;

	cbb_flag_alu i_cbb_flag_alu (
		.op        (issue.op),
		.a         (issue.rd_val),
		.b         (alu_b),
		.flags_in  (status_register_q),
		.result    (alu_res),
		.flags_out (alu_flags),
		.flags_wr  (alu_flags_wr)
	);

	// One bit forced, all others pass through
	for (genvar i = 0; i < 8; i++) begin : g_io_bit
		assign io_forced[i] = (issue.bit_sel == 3'(i))
			? (issue.op == OP_SET_IO_BIT) : issue.io_val[i];
	end

	// Condition of each skip and branch
	always_comb begin
		hit = 1'b0;
		is_skip = 1'b0;
		is_branch = 1'b0;
		is_io_bit = 1'b0;
		case (issue.op)
			OP_COMPARE_SKIP_EQUAL: begin
				is_skip = 1'b1;
				hit = (issue.rd_val == issue.rr_val);
			end
			OP_SKIP_REG_BIT_CLEAR: begin
				is_skip = 1'b1;
				hit = ~issue.rr_val[issue.bit_sel];
			end
			OP_SKIP_REG_BIT_SET: begin
				is_skip = 1'b1;
				hit = issue.rr_val[issue.bit_sel];
			end
			OP_SKIP_IO_BIT_CLEAR: begin
				is_skip = 1'b1;
				hit = ~issue.io_val[issue.bit_sel];
			end
			OP_SKIP_IO_BIT_SET: begin
				is_skip = 1'b1;
				hit = issue.io_val[issue.bit_sel];
			end
			OP_BRANCH_FLAG_INDEX_SET: begin
				is_branch = 1'b1;
				hit = fl[issue.flag_sel];
			end
			OP_BRANCH_FLAG_INDEX_CLEAR: begin
				is_branch = 1'b1;
				hit = ~fl[issue.flag_sel];
			end
			OP_BRANCH_EQUAL: begin
				is_branch = 1'b1;
				hit = fl[`CBB_FLAG_Z];
			end
			OP_BRANCH_NOT_EQUAL: begin
				is_branch = 1'b1;
				hit = ~fl[`CBB_FLAG_Z];
			end
			OP_BRANCH_CARRY_SET,
			OP_BRANCH_LOWER: begin
				is_branch = 1'b1;
				hit = fl[`CBB_FLAG_C];
			end
			OP_BRANCH_CARRY_CLEAR,
			OP_BRANCH_SAME_OR_HIGHER: begin
				is_branch = 1'b1;
				hit = ~fl[`CBB_FLAG_C];
			end
			OP_BRANCH_MINUS: begin
				is_branch = 1'b1;
				hit = fl[`CBB_FLAG_N];
			end
			OP_BRANCH_PLUS: begin
				is_branch = 1'b1;
				hit = ~fl[`CBB_FLAG_N];
			end
			OP_BRANCH_GREATER_EQUAL_SIGNED: begin
				is_branch = 1'b1;
				hit = ~(fl[`CBB_FLAG_N] ^ fl[`CBB_FLAG_V]);
			end
			OP_BRANCH_LESS_SIGNED: begin
				is_branch = 1'b1;
				hit = fl[`CBB_FLAG_N] ^ fl[`CBB_FLAG_V];
			end
			OP_BRANCH_HALF_CARRY_SET: begin
				is_branch = 1'b1;
				hit = fl[`CBB_FLAG_H];
			end
			OP_BRANCH_HALF_CARRY_CLEAR: begin
				is_branch = 1'b1;
				hit = ~fl[`CBB_FLAG_H];
			end
			OP_BRANCH_TRANSFER_FLAG_SET: begin
				is_branch = 1'b1;
				hit = fl[`CBB_FLAG_T];
			end
			OP_BRANCH_TRANSFER_FLAG_CLEAR: begin
				is_branch = 1'b1;
				hit = ~fl[`CBB_FLAG_T];
			end
			OP_BRANCH_OVERFLOW_SET: begin
				is_branch = 1'b1;
				hit = fl[`CBB_FLAG_V];
			end
			OP_BRANCH_OVERFLOW_CLEAR: begin
				is_branch = 1'b1;
				hit = ~fl[`CBB_FLAG_V];
			end
			OP_BRANCH_INT_ENABLED: begin
				is_branch = 1'b1;
				hit = fl[`CBB_FLAG_I];
			end
			OP_BRANCH_INT_DISABLED: begin
				is_branch = 1'b1;
				hit = ~fl[`CBB_FLAG_I];
			end
			OP_SET_IO_BIT,
			OP_CLEAR_IO_BIT: begin
				is_io_bit = 1'b1;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// Next program counter and cycle count
	always_comb begin
		pc_cur = issue.pc[PC_W-1:0];
		pc_inc = pc_cur + PC_W'(`CBB_LEN_1W);
		k_ext = {{(PC_W-7){issue.k[6]}}, issue.k};
		pc_new = pc_inc;
		cyc = `CBB_CYC_BASE;
		if (is_skip && hit) begin
			if (issue.next_two_word) begin
				pc_new = pc_inc + PC_W'(`CBB_LEN_2W);
				cyc = `CBB_CYC_SKIP2;
			end else begin
				pc_new = pc_inc + PC_W'(`CBB_LEN_1W);
				cyc = `CBB_CYC_SKIP1;
			end
		end else if (is_branch && hit) begin
			pc_new = pc_inc + k_ext;
			cyc = `CBB_CYC_BRANCH;
		end else if (is_io_bit) begin
			cyc = `CBB_CYC_IO_BIT;
		end
	end

	// Answer assembled in the cycle the instruction is taken
	always_comb begin
		calc = '0;
		calc.pc_next = cbb_pc_t'(pc_new);
		calc.taken = (is_skip | is_branch) & hit;
		calc.rd_wr = alu_flags_wr & (issue.op >= OP_LOGICAL_SHIFT_LEFT);
		calc.rd_data = calc.rd_wr ? alu_res : `CBB_ZERO_BYTE;
		calc.io_wr = is_io_bit;
		calc.io_addr = issue.io_addr;
		calc.io_data = is_io_bit ? io_forced : `CBB_ZERO_BYTE;
	end

	// Sequencer: holds the answer back for multi-cycle instructions
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			cnt_q <= 2'h0;
			pend_q <= '0;
		end else if (ce) begin
			case (state_q)
				ST_IDLE: begin
					if (take && cyc != `CBB_CYC_BASE) begin
						state_q <= ST_BUSY;
						cnt_q <= cyc - 2'h2;
						pend_q <= calc;
					end
				end
				ST_BUSY: begin
					if (cnt_q == 2'h0) begin
						state_q <= ST_IDLE;
					end else begin
						cnt_q <= cnt_q - 2'h1;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			res_valid_q <= 1'b0;
			res_q <= '0;
		end else if (ce) begin
			res_valid_q <= 1'b0;
			if (take && cyc == `CBB_CYC_BASE) begin
				res_valid_q <= 1'b1;
				res_q <= calc;
			end else if (state_q == ST_BUSY && cnt_q == 2'h0) begin
				res_valid_q <= 1'b1;
				res_q <= pend_q;
			end
		end
	end

	// Instruction update wins over a software write in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_register_q <= `CBB_STATUS_REG_RST;
		end else if (ce) begin
			if (take && alu_flags_wr) begin
				status_register_q <= alu_flags;
			end else if (reg_wr && reg_addr == `CBB_ADDR_STATUS_REG) begin
				status_register_q <= reg_wdata;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= `CBB_CTRL_RST;
		end else if (ce) begin
			if (reg_wr && reg_addr == `CBB_ADDR_CTRL) begin
				ctrl_q <= reg_wdata;
			end
		end
	end

	// Taken counter: an increment wins over a clearing write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			last_taken_q <= 1'b0;
			taken_cnt_q <= `CBB_ZERO_BYTE;
		end else if (ce) begin
			if (take) begin
				last_taken_q <= calc.taken;
			end
			if (take && calc.taken) begin
				taken_cnt_q <= taken_cnt_q + 8'h01;
			end else if (reg_wr && reg_addr == `CBB_ADDR_TAKEN_CNT) begin
				taken_cnt_q <= `CBB_ZERO_BYTE;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= `CBB_ZERO_BYTE;
		end else if (ce) begin
			rdata_q <= `CBB_ZERO_BYTE;
			if (reg_rd) begin
				case (reg_addr)
					`CBB_ADDR_STATUS_REG: rdata_q <= status_register_q;
					`CBB_ADDR_CTRL:       rdata_q <= ctrl_q;
					`CBB_ADDR_STAT: begin
						rdata_q[`CBB_STAT_BUSY] <= (state_q == ST_BUSY);
						rdata_q[`CBB_STAT_TAKEN] <= last_taken_q;
					end
					`CBB_ADDR_PC_LO:      rdata_q <= res_q.pc_next[7:0];
					`CBB_ADDR_PC_HI:      rdata_q <= res_q.pc_next[15:8];
					`CBB_ADDR_TAKEN_CNT:  rdata_q <= taken_cnt_q;
					default:              rdata_q <= `CBB_ZERO_BYTE;
				endcase
			end
		end
	end

endmodule : cbb_unit

`default_nettype wire

// ### hdl/cbb_map.svh
`ifndef CBB_MAP_SVH
`define CBB_MAP_SVH

// Status register bit positions
`define CBB_FLAG_C 0
`define CBB_FLAG_Z 1
`define CBB_FLAG_N 2
`define CBB_FLAG_V 3
`define CBB_FLAG_S 4
`define CBB_FLAG_H 5
`define CBB_FLAG_T 6
`define CBB_FLAG_I 7

// Register port addresses
`define CBB_ADDR_STATUS_REG 4'h0
`define CBB_ADDR_CTRL       4'h1
`define CBB_ADDR_STAT       4'h2
`define CBB_ADDR_PC_LO      4'h3
`define CBB_ADDR_PC_HI      4'h4
`define CBB_ADDR_TAKEN_CNT  4'h5

// Register fields and reset values
`define CBB_CTRL_EN          0
`define CBB_STAT_BUSY        0
`define CBB_STAT_TAKEN       1
`define CBB_CTRL_RST         8'h01
`define CBB_STATUS_REG_RST   8'h00
`define CBB_ZERO_BYTE        8'h00

// Cycle counts per instruction class
`define CBB_CYC_BASE   2'h1
`define CBB_CYC_BRANCH 2'h2
`define CBB_CYC_SKIP1  2'h2
`define CBB_CYC_SKIP2  2'h3
`define CBB_CYC_IO_BIT 2'h2

// Program counter steps in words
`define CBB_LEN_1W 1
`define CBB_LEN_2W 2

`endif

// ### hdl/cbb_pkg.sv
package cbb_pkg;

	typedef enum logic [5:0] {
		OP_NOP                        = 6'h00,
		OP_COMPARE_SKIP_EQUAL         = 6'h01,
		OP_COMPARE_REGS               = 6'h02,
		OP_COMPARE_REGS_WITH_CARRY    = 6'h03,
		OP_COMPARE_IMMEDIATE          = 6'h04,
		OP_SKIP_REG_BIT_CLEAR         = 6'h05,
		OP_SKIP_REG_BIT_SET           = 6'h06,
		OP_SKIP_IO_BIT_CLEAR          = 6'h07,
		OP_SKIP_IO_BIT_SET            = 6'h08,
		OP_BRANCH_FLAG_INDEX_SET      = 6'h09,
		OP_BRANCH_FLAG_INDEX_CLEAR    = 6'h0A,
		OP_BRANCH_EQUAL               = 6'h0B,
		OP_BRANCH_NOT_EQUAL           = 6'h0C,
		OP_BRANCH_CARRY_SET           = 6'h0D,
		OP_BRANCH_CARRY_CLEAR         = 6'h0E,
		OP_BRANCH_SAME_OR_HIGHER      = 6'h0F,
		OP_BRANCH_LOWER               = 6'h10,
		OP_BRANCH_MINUS               = 6'h11,
		OP_BRANCH_PLUS                = 6'h12,
		OP_BRANCH_GREATER_EQUAL_SIGNED = 6'h13,
		OP_BRANCH_LESS_SIGNED         = 6'h14,
		OP_BRANCH_HALF_CARRY_SET      = 6'h15,
		OP_BRANCH_HALF_CARRY_CLEAR    = 6'h16,
		OP_BRANCH_TRANSFER_FLAG_SET   = 6'h17,
		OP_BRANCH_TRANSFER_FLAG_CLEAR = 6'h18,
		OP_BRANCH_OVERFLOW_SET        = 6'h19,
		OP_BRANCH_OVERFLOW_CLEAR      = 6'h1A,
		OP_BRANCH_INT_ENABLED         = 6'h1B,
		OP_BRANCH_INT_DISABLED        = 6'h1C,
		OP_SET_IO_BIT                 = 6'h1D,
		OP_CLEAR_IO_BIT               = 6'h1E,
		OP_LOGICAL_SHIFT_LEFT         = 6'h20,
		OP_LOGICAL_SHIFT_RIGHT        = 6'h21,
		OP_ROTATE_LEFT_CARRY          = 6'h22,
		OP_ROTATE_RIGHT_CARRY         = 6'h23,
		OP_ARITH_SHIFT_RIGHT          = 6'h24
	} cbb_op_e;

	typedef enum logic {
		ST_IDLE = 1'h0,
		ST_BUSY = 1'h1
	} cbb_state_e;

	typedef logic [15:0] cbb_pc_t;

	typedef struct packed {
		cbb_op_e    op;
		logic [7:0] rd_val;
		logic [7:0] rr_val;
		logic [7:0] imm;
		logic [2:0] bit_sel;
		logic [2:0] flag_sel;
		logic [6:0] k;
		logic [7:0] io_addr;
		logic [7:0] io_val;
		logic       next_two_word;
		cbb_pc_t    pc;
	} cbb_issue_s;

	typedef struct packed {
		cbb_pc_t    pc_next;
		logic       taken;
		logic       rd_wr;
		logic [7:0] rd_data;
		logic       io_wr;
		logic [7:0] io_addr;
		logic [7:0] io_data;
	} cbb_result_s;

endpackage : cbb_pkg

// ### hdl/cbb_flag_alu.sv
`timescale 1ns/10ps
`default_nettype none
`include "cbb_map.svh"

module cbb_flag_alu
	import cbb_pkg::*;
(
	input  wire cbb_op_e    op,
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	input  wire logic [7:0] flags_in,
	output logic [7:0]      result,
	output logic [7:0]      flags_out,
	output logic            flags_wr
);

	logic [8:0] diff;
	logic       cin;
	logic       cy;

	assign cin = flags_in[`CBB_FLAG_C];

	always_comb begin
		cy = (op == OP_COMPARE_REGS_WITH_CARRY) ? cin : 1'b0;
		diff = {1'b0, a} - {1'b0, b} - {8'h00, cy};
		result = diff[7:0];
		flags_out = flags_in;
		flags_wr = 1'b0;
		case (op)
			OP_COMPARE_REGS,
			OP_COMPARE_REGS_WITH_CARRY,
			OP_COMPARE_IMMEDIATE: begin
				flags_wr = 1'b1;
				flags_out[`CBB_FLAG_C] = diff[8];
				flags_out[`CBB_FLAG_N] = diff[7];
				flags_out[`CBB_FLAG_H] = (~a[3] & b[3]) | (b[3] & diff[3])
					| (diff[3] & ~a[3]);
				flags_out[`CBB_FLAG_V] = (a[7] & ~b[7] & ~diff[7])
					| (~a[7] & b[7] & diff[7]);
				// With carry, zero only survives a chain of zero results
				if (op == OP_COMPARE_REGS_WITH_CARRY) begin
					flags_out[`CBB_FLAG_Z] = (diff[7:0] == 8'h00)
						& flags_in[`CBB_FLAG_Z];
				end else begin
					flags_out[`CBB_FLAG_Z] = (diff[7:0] == 8'h00);
				end
			end
			OP_LOGICAL_SHIFT_LEFT,
			OP_ROTATE_LEFT_CARRY,
			OP_LOGICAL_SHIFT_RIGHT,
			OP_ROTATE_RIGHT_CARRY,
			OP_ARITH_SHIFT_RIGHT: begin
				flags_wr = 1'b1;
				case (op)
					OP_LOGICAL_SHIFT_LEFT: begin
						result = {a[6:0], 1'b0};
						flags_out[`CBB_FLAG_C] = a[7];
					end
					OP_ROTATE_LEFT_CARRY: begin
						result = {a[6:0], cin};
						flags_out[`CBB_FLAG_C] = a[7];
					end
					OP_LOGICAL_SHIFT_RIGHT: begin
						result = {1'b0, a[7:1]};
						flags_out[`CBB_FLAG_C] = a[0];
					end
					OP_ROTATE_RIGHT_CARRY: begin
						result = {cin, a[7:1]};
						flags_out[`CBB_FLAG_C] = a[0];
					end
					default: begin
						result = {a[7], a[7:1]};
						flags_out[`CBB_FLAG_C] = a[0];
					end
				endcase
				flags_out[`CBB_FLAG_N] = result[7];
				flags_out[`CBB_FLAG_Z] = (result == 8'h00);
				flags_out[`CBB_FLAG_V] = result[7] ^ flags_out[`CBB_FLAG_C];
			end
			default: begin
				flags_wr = 1'b0;
			end
		endcase
	end

endmodule : cbb_flag_alu

`default_nettype wire

// ### test/cbb_unit_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module cbb_unit_asserts
	import cbb_pkg::*;
#(
	parameter int PC_W = 16
)
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        issue_valid,
	input  wire cbb_issue_s  issue,
	input  wire logic        issue_ready,
	input  wire logic        res_valid,
	input  wire cbb_result_s res,
	input  wire logic [7:0]  status_register,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_rdata
);
	logic       take;
	cbb_issue_s last_q;
	assign take = ce & issue_valid & issue_ready;
	// Operands of the instruction in flight
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			last_q <= '0;
		else if (take)
			last_q <= issue;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_wait;
		!res_valid && !issue_ready;
	endsequence
	sequence s_jump;
		res_valid && res.taken &&
			res.pc_next == last_q.pc + 16'h1 + {{9{last_q.k[6]}}, last_q.k};
	endsequence
	property p_cmp_one;
		take && issue.op inside {[OP_COMPARE_REGS:OP_COMPARE_IMMEDIATE]}
			|=> res_valid && !res.taken && !res.rd_wr;
	endproperty
	a_cmp_one: assert property (p_cmp_one)
		else $error("compare answer late or wrong");
	property p_shift_one;
		take && issue.op >= OP_LOGICAL_SHIFT_LEFT |=> res_valid && res.rd_wr;
	endproperty
	a_shift_one: assert property (p_shift_one)
		else $error("shift answer late");
	property p_io_set;
		take && issue.op == OP_SET_IO_BIT |=> s_wait ##1 (res_valid &&
			res.io_data == (last_q.io_val | (8'h01 << last_q.bit_sel)));
	endproperty
	a_io_set: assert property (p_io_set)
		else $error("io bit set wrong");
	property p_skip_two;
		take && issue.op == OP_COMPARE_SKIP_EQUAL && issue.next_two_word &&
			issue.rd_val == issue.rr_val |=> s_wait ##1 s_wait ##1
			(res_valid && res.pc_next == last_q.pc + 16'h3);
	endproperty
	a_skip_two: assert property (p_skip_two)
		else $error("skip over two words wrong");
	property p_skip_one;
		take && issue.op == OP_SKIP_IO_BIT_SET && !issue.next_two_word &&
			issue.io_val[issue.bit_sel] |=> s_wait ##1 res_valid;
	endproperty
	a_skip_one: assert property (p_skip_one)
		else $error("skip over one word wrong");
	property p_br_taken;
		take && issue.op == OP_BRANCH_EQUAL && status_register[1]
			|=> s_wait ##1 s_jump;
	endproperty
	a_br_taken: assert property (p_br_taken)
		else $error("taken branch wrong");
	property p_br_less;
		take && issue.op == OP_BRANCH_LESS_SIGNED &&
			(status_register[2] ^ status_register[3]) |=> s_wait ##1 s_jump;
	endproperty
	a_br_less: assert property (p_br_less)
		else $error("signed branch wrong");
	property p_br_not;
		take && issue.op == OP_BRANCH_NOT_EQUAL && status_register[1]
			|=> res_valid && !res.taken && res.pc_next == last_q.pc + 16'h1;
	endproperty
	a_br_not: assert property (p_br_not)
		else $error("untaken branch wrong");
	property p_flags_kept;
		take && !reg_wr &&
			issue.op inside {[OP_SKIP_REG_BIT_CLEAR:OP_CLEAR_IO_BIT]}
			|=> $stable(status_register);
	endproperty
	a_flags_kept: assert property (p_flags_kept)
		else $error("flags changed by branch or skip");
endmodule : cbb_unit_asserts
bind cbb_unit cbb_unit_asserts #(.PC_W(PC_W)) i_cbb_unit_asserts (
	.clk(clk), .rst(rst), .ce(ce), .issue_valid(issue_valid),
	.issue(issue), .issue_ready(issue_ready), .res_valid(res_valid),
	.res(res), .status_register(status_register), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata));
`default_nettype wire

// ### test/test_compare_branch_bit_unit.sv
`timescale 1ns/10ps
`default_nettype none
module test_compare_branch_bit_unit
	import cbb_pkg::*;
;
	typedef struct {
		cbb_pc_t pc; logic tk; logic [1:0] wr; logic [7:0] rd;
		logic [15:0] io; logic [7:0] fl; int n; int t;
	} cbb_note_s;
	logic        clk = 0, rst = 1, ce = 1, issue_valid = 0;
	logic        reg_wr = 0, reg_rd = 0, issue_ready, res_valid;
	logic [3:0]  reg_addr = '0;
	logic [7:0]  reg_wdata = '0, status_register, reg_rdata, s_m, w;
	cbb_issue_s  issue = '0, x;
	cbb_result_s res;
	cbb_op_e     op;
	cbb_pc_t     last_pc = '0;
	logic        last_tk = 1'b0;
	cbb_note_s   q[$], mq;
	int          n_fail = 0, n_tests = 0, cyc = 0, ntk = 0, i;
	cbb_unit i_cbb_unit (.clk(clk), .rst(rst), .ce(ce),
		.issue_valid(issue_valid), .issue(issue), .issue_ready(issue_ready),
		.res_valid(res_valid), .res(res), .status_register(status_register),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	always #5 clk = ~clk;
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] s);
		n_tests++;
		if (e !== s) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task final_report;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report
	function automatic cbb_note_s model(cbb_issue_s x, logic [7:0] s);
		cbb_note_s m;
		logic [8:0] r;
		logic [4:0] h;
		logic [7:0] b;
		logic c, sk, br;
		m = '{x.pc + 16'h1, 1'b0, 2'h0, 8'h00, 16'h0, s, 1, 0};
		b = (x.op == OP_COMPARE_IMMEDIATE) ? x.imm : x.rr_val;
		c = (x.op == OP_COMPARE_REGS_WITH_CARRY) & s[0];
		r = {1'b0, x.rd_val} - {1'b0, b} - c;
		h = {1'b0, x.rd_val[3:0]} - {1'b0, b[3:0]} - c;
		sk = 1'b0;
		br = 1'b0;
		case (x.op)
			OP_COMPARE_REGS, OP_COMPARE_REGS_WITH_CARRY, OP_COMPARE_IMMEDIATE:
				m.fl = {s[7:6], h[4], s[4], (x.rd_val[7] ^ b[7]) &
					(r[7] ^ x.rd_val[7]), r[7], ~|r[7:0] &
					(x.op != OP_COMPARE_REGS_WITH_CARRY | s[1]), r[8]};
			OP_COMPARE_SKIP_EQUAL: sk = x.rd_val == x.rr_val;
			OP_SKIP_REG_BIT_CLEAR: sk = !x.rr_val[x.bit_sel];
			OP_SKIP_REG_BIT_SET: sk = x.rr_val[x.bit_sel];
			OP_SKIP_IO_BIT_CLEAR: sk = !x.io_val[x.bit_sel];
			OP_SKIP_IO_BIT_SET: sk = x.io_val[x.bit_sel];
			OP_BRANCH_FLAG_INDEX_SET: br = s[x.flag_sel];
			OP_BRANCH_FLAG_INDEX_CLEAR: br = !s[x.flag_sel];
			OP_BRANCH_EQUAL: br = s[1];
			OP_BRANCH_NOT_EQUAL: br = !s[1];
			OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: br = s[0];
			OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER: br = !s[0];
			OP_BRANCH_MINUS: br = s[2];
			OP_BRANCH_PLUS: br = !s[2];
			OP_BRANCH_GREATER_EQUAL_SIGNED: br = !(s[2] ^ s[3]);
			OP_BRANCH_LESS_SIGNED: br = s[2] ^ s[3];
			OP_BRANCH_HALF_CARRY_SET: br = s[5];
			OP_BRANCH_HALF_CARRY_CLEAR: br = !s[5];
			OP_BRANCH_TRANSFER_FLAG_SET: br = s[6];
			OP_BRANCH_TRANSFER_FLAG_CLEAR: br = !s[6];
			OP_BRANCH_OVERFLOW_SET: br = s[3];
			OP_BRANCH_OVERFLOW_CLEAR: br = !s[3];
			OP_BRANCH_INT_ENABLED: br = s[7];
			OP_BRANCH_INT_DISABLED: br = !s[7];
			OP_SET_IO_BIT: m.io = {x.io_addr, x.io_val | (8'h01 << x.bit_sel)};
			OP_CLEAR_IO_BIT: m.io = {x.io_addr, x.io_val & ~(8'h01 << x.bit_sel)};
			OP_LOGICAL_SHIFT_LEFT: r = {x.rd_val, 1'b0};
			OP_ROTATE_LEFT_CARRY: r = {x.rd_val, s[0]};
			OP_LOGICAL_SHIFT_RIGHT: r = {x.rd_val[0], 1'b0, x.rd_val[7:1]};
			OP_ROTATE_RIGHT_CARRY: r = {x.rd_val[0], s[0], x.rd_val[7:1]};
			OP_ARITH_SHIFT_RIGHT: r = {x.rd_val[0], x.rd_val[7], x.rd_val[7:1]};
			default: ;
		endcase
		if (x.op >= OP_LOGICAL_SHIFT_LEFT) begin
			m.wr = 2'h2;
			m.rd = r[7:0];
			m.fl[3:0] = {r[7] ^ r[8], r[7], ~|r[7:0], r[8]};
		end
		if (x.op inside {OP_SET_IO_BIT, OP_CLEAR_IO_BIT}) begin
			m.wr = 2'h1;
			m.n = 2;
		end
		if (sk) begin
			m.tk = 1'b1;
			m.n = x.next_two_word ? 3 : 2;
			m.pc = x.pc + 16'(m.n);
		end
		if (br) begin
			m.tk = 1'b1;
			m.n = 2;
			m.pc = x.pc + 16'h1 + {{9{x.k[6]}}, x.k};
		end
		return m;
	endfunction : model
	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : reg_write
	task automatic reg_read(input logic [3:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		chk("reg_rdata", e, reg_rdata);
	endtask : reg_read
	// Holds the request until an edge takes it, then notes the expectation
	task automatic issue_op(input cbb_issue_s v);
		cbb_note_s m;
		issue_valid <= 1'b1;
		issue <= v;
		do @(posedge clk); while (issue_ready !== 1'b1);
		m = model(v, s_m);
		m.t = cyc;
		s_m = m.fl;
		ntk += m.tk;
		q.push_back(m);
	endtask : issue_op
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			final_report();
		end else if (res_valid === 1'b1) begin
			if (q.size() == 0)
				chk("extra result", 16'h0, 16'h1);
			else begin
				mq = q.pop_front();
				last_pc = mq.pc;
				last_tk = mq.tk;
				chk("pc_next", mq.pc, res.pc_next);
				chk("taken", mq.tk, res.taken);
				chk("flags", mq.fl, status_register);
				chk("cycles", 16'(mq.n), 16'(cyc - mq.t));
				chk("writes", mq.wr, {res.rd_wr, res.io_wr});
				if (mq.wr[1])
					chk("shift", mq.rd, res.rd_data);
				if (mq.wr[0])
					chk("io byte", mq.io, {res.io_addr, res.io_data});
			end
		end
	end
	initial begin
		void'($urandom(32'hB523));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		reg_read(4'h1, 8'h01);
		reg_read(4'h0, 8'h00);
		reg_write(4'h0, 8'hA5);
		reg_read(4'h0, 8'hA5);
		reg_write(4'hF, 8'hFF);
		reg_read(4'hF, 8'h00);
		reg_read(4'h1, 8'h01);
		reg_write(4'h1, 8'h00);
		chk("ready off", 16'h0, issue_ready);
		reg_write(4'h1, 8'h01);
		reg_write(4'h5, 8'h00);
		// A write while the clock enable is low must be lost
		ce <= 1'b0;
		reg_write(4'h0, 8'h3C);
		chk("ce freeze", 16'hA5, status_register);
		ce <= 1'b1;
		s_m = 8'hA5;
		$display("test register port done");
		op = op.first();
		for (i = 0; i < 700; i++) begin
			if (i % 3 == 0) begin
				// Drop the request first, or the block takes it again
				issue_valid <= 1'b0;
				while (q.size() != 0) @(posedge clk);
				w = 8'($urandom);
				reg_write(4'h0, w);
				s_m = w;
			end
			x = 76'({$urandom, $urandom, $urandom});
			x.op = op;
			if ($urandom % 2 || op inside {[OP_SKIP_REG_BIT_CLEAR:OP_SKIP_REG_BIT_SET]})
				x.rr_val = x.rd_val;
			issue_op(x);
			op = op.next();
		end
		issue_valid <= 1'b0;
		repeat (4) @(posedge clk);
		chk("pending", 16'h0, 16'(q.size()));
		reg_read(4'h3, last_pc[7:0]);
		reg_read(4'h4, last_pc[15:8]);
		reg_read(4'h5, ntk[7:0]);
		reg_read(4'h2, {6'h00, last_tk, 1'b0});
		$display("test instructions done");
		final_report();
	end
endmodule : test_compare_branch_bit_unit
`default_nettype wire
